// ---- inc/pfs_pkg.sv ----
/*
  Shared constants and types of the power stage fault supervisor.
  Assumes a single 25 MHz core clock and the plain register port.
*/
package pfs_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CHECK_US_PER_UF = 15000;
  // Longest time per step, rounded down: two steps share it
  localparam int unsigned CHECK_STEP_CYC = (CHECK_US_PER_UF * (CLK_HZ / 1_000_000)) / 2;
  localparam int unsigned CHECK_CNT_W = 18;
  localparam int unsigned CAP_W = 4;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_PKG64_BIT = 2;
  localparam int unsigned CTRL_CAP_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0014;
  localparam logic [31:0] CTRL_MASK = 32'h0000_00F7;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_CHECK_DONE_BIT = 7;
  localparam int unsigned STAT_OTE_BIT = 8;
  localparam int unsigned STAT_OVERLOAD_BIT = 9;
  localparam int unsigned STAT_UNDERVOLT_BIT = 10;
  localparam int unsigned STAT_READY_BIT = 11;
  localparam int unsigned STAT_PINS_LSB = 12;
  localparam int unsigned STAT_BOOT_LSB = 20;
  localparam int unsigned STAT_OC_LSB = 24;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LOAD_BRIDGE_TIED = 2'h0,
    LOAD_PARALLEL_BRIDGE = 2'h1,
    LOAD_SINGLE_ENDED = 2'h2
  } pfs_load_t;

  typedef enum logic [6:0] {
    ST_POWER_CLEAR = 7'h01,
    ST_CHECK_GND = 7'h02,
    ST_CHECK_SUPPLY = 7'h04,
    ST_HELD_RESET = 7'h08,
    ST_RUN = 7'h10,
    ST_UNDERVOLT = 7'h20,
    ST_FAULT_LATCH = 7'h40
  } pfs_state_t;

  typedef struct packed {
    logic dev_reset_n;
    logic [3:0] short_gnd;
    logic [3:0] short_supply;
    logic temp_over_100;
    logic temp_over_125;
    logic temp_over_155;
    logic common_supply_low;
    logic [3:0] gate_drive_low;
    logic overload;
    logic [3:0] overcurrent;
    logic [3:0] bootstrap_low;
    logic trim_at_regulator;
    logic [4:0] pins;
  } pfs_async_t;
endpackage

// ---- inc/pfs_sync_if.sv ----
/*
  Carrier between the supervisor and its input synchroniser.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
interface pfs_sync_if;
  pfs_pkg::pfs_async_t raw;
  pfs_pkg::pfs_async_t synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface

// ---- verification/pfs_ctrl_model.sv ----
/*
  Controller model at the far side: reads the shutdown pin, drives the device reset.
  Assumes the bench resolves the open-drain pin and requests resets on core_clk.
*/
`timescale 1ns/1ps
module pfs_ctrl_model #(
  parameter int unsigned HOLD_CYC = 20
) (
  input wire logic core_clk,
  input wire logic shutdown_flag_n,
  input wire logic reset_req,
  output logic dev_reset_n
);
  // ==========================================================
  // Hold-off counter from the last shutdown fall
  int unsigned since_fall_q = 0;
  logic flag_q = 1'b1;
  initial dev_reset_n = 1'b0;
  always @(posedge core_clk) begin
    flag_q <= shutdown_flag_n;
    if (flag_q && !shutdown_flag_n) begin
      since_fall_q <= 0;
    end else if (since_fall_q < HOLD_CYC) begin
      since_fall_q <= since_fall_q + 1;
    end
    // Reset asserted at once, released only after hold-off
    if (reset_req) begin
      dev_reset_n <= 1'b0;
    end else if (since_fall_q >= HOLD_CYC) begin
      dev_reset_n <= 1'b1;
    end
  end
endmodule

// ---- verification/pfs_supervisor_tb_top.sv ----
/*
  Self-checking bench of the fault supervisor with a controller model.
  Assumes the short check step is shortened to 8 cycles per microfarad.
*/
`timescale 1ns/1ps
`define CHK(a, e) cmp(32'(a), 32'(e))
module pfs_supervisor_tb_top;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reset_req = 1'b0;
  logic [3:0] reg_addr = 4'h0, short_to_gnd = 4'h2, short_to_supply = 4'h4;
  logic [3:0] gate_drive_low = 4'h0, overcurrent_detect = 4'h0, bootstrap_low = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic temp_over_100c = 1'b0, temp_over_125c = 1'b0, temp_over_155c = 1'b0;
  logic common_supply_low = 1'b0, overload_detect = 1'b0, trim_at_regulator = 1'b0;
  logic ext_q = 1'b0, dev_reset_n, ready, osc_run, oscillator_io_drv, oscillator_io_oe_n;
  logic [3:0] bridge_hiz, bridge_weak_pd;
  logic shutdown_flag_n_drv, shutdown_flag_n_oe_n, temp_warning_n_drv, temp_warning_n_oe_n;
  logic temp_warn_low_n_drv, temp_warn_low_n_oe_n, temp_warn_high_n_drv, temp_warn_high_n_oe_n;
  logic [6:0] r;
  int n_mismatch = 0, samples_checked = 0;
  // Rows: package, t100, t125, overcurrent, two warning levels, ready
  localparam logic [6:0] ROWS [6] = '{7'h47, 7'h63, 7'h71, 7'h25, 7'h31, 7'h0C};
  // Open-drain pins see the pull-up whenever released
  wire shutdown_flag_n_pin = shutdown_flag_n_oe_n | shutdown_flag_n_drv;
  wire temp_warning_n_pin = temp_warning_n_oe_n | temp_warning_n_drv;
  wire temp_warn_low_n_pin = temp_warn_low_n_oe_n | temp_warn_low_n_drv;
  wire temp_warn_high_n_pin = temp_warn_high_n_oe_n | temp_warn_high_n_drv;
  wire oscillator_io_pin = oscillator_io_oe_n ? ext_q : oscillator_io_drv;

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) ext_q <= ~ext_q;

  pfs_supervisor #(.CHECK_STEP_CYCLES(8)) dut (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dev_reset_n(dev_reset_n),
    .short_to_gnd(short_to_gnd),
    .short_to_supply(short_to_supply),
    .temp_over_100c(temp_over_100c),
    .temp_over_125c(temp_over_125c),
    .temp_over_155c(temp_over_155c),
    .common_supply_low(common_supply_low),
    .gate_drive_low(gate_drive_low),
    .overload_detect(overload_detect),
    .overcurrent_detect(overcurrent_detect),
    .bootstrap_low(bootstrap_low),
    .trim_at_regulator(trim_at_regulator),
    .bridge_hiz(bridge_hiz),
    .bridge_weak_pd(bridge_weak_pd),
    .ready(ready),
    .shutdown_flag_n_drv(shutdown_flag_n_drv),
    .shutdown_flag_n_oe_n(shutdown_flag_n_oe_n),
    .shutdown_flag_n_pin(shutdown_flag_n_pin),
    .temp_warning_n_drv(temp_warning_n_drv),
    .temp_warning_n_oe_n(temp_warning_n_oe_n),
    .temp_warning_n_pin(temp_warning_n_pin),
    .temp_warn_low_n_drv(temp_warn_low_n_drv),
    .temp_warn_low_n_oe_n(temp_warn_low_n_oe_n),
    .temp_warn_low_n_pin(temp_warn_low_n_pin),
    .temp_warn_high_n_drv(temp_warn_high_n_drv),
    .temp_warn_high_n_oe_n(temp_warn_high_n_oe_n),
    .temp_warn_high_n_pin(temp_warn_high_n_pin),
    .osc_run(osc_run),
    .oscillator_io_drv(oscillator_io_drv),
    .oscillator_io_oe_n(oscillator_io_oe_n),
    .oscillator_io_pin(oscillator_io_pin)
  );
  pfs_ctrl_model #(.HOLD_CYC(20)) ctrl (.core_clk(core_clk), .shutdown_flag_n(shutdown_flag_n_pin),
    .reset_req(reset_req), .dev_reset_n(dev_reset_n));

  // ==========================================================
  // Helpers
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    samples_checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1) begin
      if (k == 400) begin
        n_mismatch++;
        summarize();
      end
      k++;
      @(posedge core_clk);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    cyc(12);
    rst <= 1'b0;
    rd(4'h0);
    `CHK(d, 32'h0000_0014);
    rd(4'h8);
    `CHK(d, 32'h0000_0000);
    cyc(30);
    reset_req <= 1'b1;
    cyc(6);
    #1;
    `CHK(shutdown_flag_n_pin, 1'b0);
    rd(4'h4);
    `CHK(d[6:0], pfs_pkg::ST_CHECK_GND);
    reset_req <= 1'b0;
    short_to_gnd <= 4'h0;
    cyc(20);
    rd(4'h4);
    `CHK(d[6:0], pfs_pkg::ST_CHECK_SUPPLY);
    `CHK(bridge_hiz, 4'hF);
    short_to_supply <= 4'h0;
    wait_ready();
    #1;
    `CHK(shutdown_flag_n_pin, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      wr(4'h0, r[6] ? 32'h0000_0015 : 32'h0000_0011);
      temp_over_100c <= r[5];
      temp_over_125c <= r[4];
      overcurrent_detect <= {3'h0, r[3]};
      cyc(6);
      #1;
      if (r[6])
        `CHK({temp_warn_low_n_pin, temp_warn_high_n_pin}, r[2:1]);
      else
        `CHK(temp_warning_n_pin, r[2]);
      `CHK(ready, r[0]);
    end
    overcurrent_detect <= 4'h0;
    temp_over_155c <= 1'b1;
    cyc(8);
    #1;
    `CHK({bridge_hiz, shutdown_flag_n_pin}, 5'h1E);
    temp_over_155c <= 1'b0;
    cyc(8);
    #1;
    `CHK(shutdown_flag_n_pin, 1'b0);
    reset_req <= 1'b1;
    cyc(6);
    #1;
    `CHK({bridge_hiz, bridge_weak_pd, shutdown_flag_n_pin}, 9'h1FF);
    reset_req <= 1'b0;
    wait_ready();
    rd(4'h4);
    `CHK(d[7:0], 8'h90);
    wr(4'h0, 32'h0000_0016);
    reset_req <= 1'b1;
    cyc(6);
    #1;
    `CHK({bridge_hiz, bridge_weak_pd}, 8'hF0);
    reset_req <= 1'b0;
    wait_ready();
    gate_drive_low <= 4'h8;
    cyc(4);
    #1;
    `CHK({bridge_hiz, shutdown_flag_n_pin}, 5'h1E);
    gate_drive_low <= 4'h0;
    wait_ready();
    #1;
    `CHK(shutdown_flag_n_pin, 1'b1);
    bootstrap_low <= 4'h2;
    cyc(6);
    #1;
    `CHK({bridge_hiz, shutdown_flag_n_pin}, 5'h05);
    trim_at_regulator <= 1'b1;
    cyc(6);
    #1;
    `CHK({osc_run, oscillator_io_oe_n}, 2'h1);
    short_to_gnd <= 4'h1;
    cyc(6);
    #1;
    `CHK({bridge_hiz, shutdown_flag_n_pin}, 5'h05);
    short_to_gnd <= 4'h0;
    overload_detect <= 1'b1;
    cyc(6);
    overload_detect <= 1'b0;
    cyc(6);
    #1;
    `CHK({bridge_hiz, shutdown_flag_n_pin}, 5'h1E);
    reset_req <= 1'b1;
    cyc(6);
    reset_req <= 1'b0;
    wait_ready();
    rd(4'h4);
    `CHK(d[9:8], 2'h0);
    summarize();
  end
endmodule

// ---- verilog/pfs_supervisor.sv ----
/*
  Fault supervisor of a four half-bridge power stage: pin short check,
  thermal, undervoltage, reset handling, flags and oscillator mode.
  Assumes comparator and pin inputs are asynchronous; register port on core_clk.
*/
`timescale 1ns/1ps
module pfs_supervisor #(
  parameter int unsigned CHECK_STEP_CYCLES = pfs_pkg::CHECK_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic dev_reset_n,
  input wire logic [3:0] short_to_gnd,
  input wire logic [3:0] short_to_supply,
  input wire logic temp_over_100c,
  input wire logic temp_over_125c,
  input wire logic temp_over_155c,
  input wire logic common_supply_low,
  input wire logic [3:0] gate_drive_low,
  input wire logic overload_detect,
  input wire logic [3:0] overcurrent_detect,
  input wire logic [3:0] bootstrap_low,
  input wire logic trim_at_regulator,
  output logic [3:0] bridge_hiz,
  output logic [3:0] bridge_weak_pd,
  output logic ready,
  output logic shutdown_flag_n_drv,
  output logic shutdown_flag_n_oe_n,
  input wire logic shutdown_flag_n_pin,
  output logic temp_warning_n_drv,
  output logic temp_warning_n_oe_n,
  input wire logic temp_warning_n_pin,
  output logic temp_warn_low_n_drv,
  output logic temp_warn_low_n_oe_n,
  input wire logic temp_warn_low_n_pin,
  output logic temp_warn_high_n_drv,
  output logic temp_warn_high_n_oe_n,
  input wire logic temp_warn_high_n_pin,
  output logic osc_run,
  output logic oscillator_io_drv,
  output logic oscillator_io_oe_n,
  input wire logic oscillator_io_pin
);
  localparam int CNT_W = pfs_pkg::CHECK_CNT_W;
  localparam int CW = pfs_pkg::CAP_W;

  // ==========================================================
  // Input synchronisation
  pfs_sync_if sif ();
  pfs_pkg::pfs_async_t s;

  // One driver for the whole bundle
  assign sif.raw = '{dev_reset_n: dev_reset_n,
                     short_gnd: short_to_gnd,
                     short_supply: short_to_supply,
                     temp_over_100: temp_over_100c,
                     temp_over_125: temp_over_125c,
                     temp_over_155: temp_over_155c,
                     common_supply_low: common_supply_low,
                     gate_drive_low: gate_drive_low,
                     overload: overload_detect,
                     overcurrent: overcurrent_detect,
                     bootstrap_low: bootstrap_low,
                     trim_at_regulator: trim_at_regulator,
                     pins: {oscillator_io_pin, temp_warn_high_n_pin, temp_warn_low_n_pin,
                            temp_warning_n_pin, shutdown_flag_n_pin}};

  pfs_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .bus(sif.sync_side)
  );

  assign s = sif.synced;

  // ==========================================================
  // State and registers
  pfs_pkg::pfs_state_t state_q;
  pfs_pkg::pfs_state_t state_d;
  logic [31:0] ctrl_q;
  logic check_done_q;
  logic thermal_shutdown_fault_q;
  logic overload_fault_q;
  logic [CNT_W-1:0] step_cnt_q;
  logic [CW-1:0] uf_cnt_q;
  logic [31:0] rdata_q;
  logic [3:0] hiz_q;
  logic [3:0] weak_pd_q;
  logic ready_q;
  logic sd_oe_n_q;
  logic warn_oe_n_q;
  logic warn_low_oe_n_q;
  logic warn_high_oe_n_q;
  logic drv_low_q;
  logic osc_run_q;
  logic osc_oe_n_q;
  logic osc_drv_q;

  // ==========================================================
  // Decode
  wire pfs_pkg::pfs_load_t load_mode = pfs_pkg::pfs_load_t'(ctrl_q[pfs_pkg::CTRL_MODE_LSB +: 2]);
  wire pkg64 = ctrl_q[pfs_pkg::CTRL_PKG64_BIT];
  wire [CW-1:0] cap_raw = ctrl_q[pfs_pkg::CTRL_CAP_LSB +: CW];
  wire [CW-1:0] cap_last = (cap_raw == '0) ? '0 : cap_raw - CW'(1);
  wire single_ended = (load_mode == pfs_pkg::LOAD_SINGLE_ENDED);
  wire supply_undervoltage = s.common_supply_low | (|s.gate_drive_low);
  wire in_check = (state_q == pfs_pkg::ST_CHECK_GND) || (state_q == pfs_pkg::ST_CHECK_SUPPLY);
  // Ground step looks only at ground shorts, supply step only at supply shorts
  wire short_now = (state_q == pfs_pkg::ST_CHECK_GND) ? (|s.short_gnd) :
                   (|s.short_supply);
  wire step_last = (step_cnt_q == CNT_W'(CHECK_STEP_CYCLES - 1));
  wire step_done = in_check && !short_now && step_last && (uf_cnt_q == cap_last);
  wire check_needed = !check_done_q && !single_ended;
  wire fault_latched = thermal_shutdown_fault_q | overload_fault_q;
  wire latch_window = (state_q == pfs_pkg::ST_RUN) || (state_q == pfs_pkg::ST_UNDERVOLT) ||
                      (state_q == pfs_pkg::ST_FAULT_LATCH);
  wire in_run = (state_q == pfs_pkg::ST_RUN);
  wire in_held = (state_q == pfs_pkg::ST_HELD_RESET);
  wire start_state_is_run = s.dev_reset_n;

  // ==========================================================
  // Fault state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      pfs_pkg::ST_POWER_CLEAR: begin
        if (!supply_undervoltage) begin
          if (check_needed) begin
            state_d = pfs_pkg::ST_CHECK_GND;
          end else if (start_state_is_run) begin
            state_d = pfs_pkg::ST_RUN;
          end else begin
            state_d = pfs_pkg::ST_HELD_RESET;
          end
        end
      end
      // Reset pin looked at only when the supply step ends, to pick run or held reset
      pfs_pkg::ST_CHECK_GND: begin
        if (supply_undervoltage) begin
          state_d = pfs_pkg::ST_POWER_CLEAR;
        end else if (step_done) begin
          state_d = pfs_pkg::ST_CHECK_SUPPLY;
        end
      end
      pfs_pkg::ST_CHECK_SUPPLY: begin
        if (supply_undervoltage) begin
          state_d = pfs_pkg::ST_POWER_CLEAR;
        end else if (step_done) begin
          state_d = start_state_is_run ? pfs_pkg::ST_RUN : pfs_pkg::ST_HELD_RESET;
        end
      end
      pfs_pkg::ST_HELD_RESET: begin
        if (s.dev_reset_n) begin
          state_d = pfs_pkg::ST_RUN;
        end
      end
      pfs_pkg::ST_RUN: begin
        if (!s.dev_reset_n) begin
          state_d = pfs_pkg::ST_HELD_RESET;
        end else if (supply_undervoltage) begin
          state_d = pfs_pkg::ST_UNDERVOLT;
        end else if (fault_latched) begin
          state_d = pfs_pkg::ST_FAULT_LATCH;
        end
      end
      pfs_pkg::ST_UNDERVOLT: begin
        if (!s.dev_reset_n) begin
          state_d = pfs_pkg::ST_HELD_RESET;
        end else if (!supply_undervoltage) begin
          state_d = pfs_pkg::ST_RUN;
        end
      end
      pfs_pkg::ST_FAULT_LATCH: begin
        if (!s.dev_reset_n) begin
          state_d = pfs_pkg::ST_HELD_RESET;
        end
      end
      default: begin
        state_d = pfs_pkg::ST_POWER_CLEAR;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= pfs_pkg::ST_POWER_CLEAR;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Short check timing
  // A short seen in a step restarts it, so the bridges stay off until clear
  always_ff @(posedge core_clk) begin
    if (rst || !in_check || short_now || step_done) begin
      step_cnt_q <= '0;
      uf_cnt_q <= '0;
    end else if (step_last) begin
      step_cnt_q <= '0;
      uf_cnt_q <= uf_cnt_q + CW'(1);
    end else begin
      step_cnt_q <= step_cnt_q + CNT_W'(1);
    end
  end

  // Only the power-on clear rewinds this, never the reset pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      check_done_q <= 1'b0;
    end else if ((state_q == pfs_pkg::ST_CHECK_SUPPLY && step_done) ||
                 (state_q == pfs_pkg::ST_POWER_CLEAR && single_ended)) begin
      check_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // Fault latches
  // No set in the held-reset state, so its clear always takes effect
  always_ff @(posedge core_clk) begin
    if (rst) begin
      thermal_shutdown_fault_q <= 1'b0;
      overload_fault_q <= 1'b0;
    end else begin
      if (latch_window && s.temp_over_155) begin
        thermal_shutdown_fault_q <= 1'b1;
      end else if (in_held) begin
        thermal_shutdown_fault_q <= 1'b0;
      end
      if (latch_window && s.overload) begin
        overload_fault_q <= 1'b1;
      end else if (in_held || state_q == pfs_pkg::ST_POWER_CLEAR) begin
        overload_fault_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Output stage, all from flops
  wire [3:0] hiz_d = in_run ? s.bootstrap_low : 4'hF;
  wire [3:0] weak_pd_d = (in_held && !single_ended) ? 4'hF : 4'h0;
  wire sd_low_d = !in_held && !in_run;
  wire ready_d = in_run && !(|s.overcurrent);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hiz_q <= 4'hF;
      weak_pd_q <= 4'h0;
      ready_q <= 1'b0;
      sd_oe_n_q <= 1'b0;
      warn_oe_n_q <= 1'b1;
      warn_low_oe_n_q <= 1'b1;
      warn_high_oe_n_q <= 1'b1;
      drv_low_q <= 1'b0;
      osc_run_q <= 1'b0;
      osc_oe_n_q <= 1'b1;
      osc_drv_q <= 1'b0;
    end else begin
      hiz_q <= hiz_d;
      weak_pd_q <= weak_pd_d;
      ready_q <= ready_d;
      sd_oe_n_q <= !sd_low_d;
      warn_low_oe_n_q <= !(pkg64 && s.temp_over_100);
      warn_high_oe_n_q <= !(pkg64 && s.temp_over_125);
      warn_oe_n_q <= !(!pkg64 && s.temp_over_125);
      drv_low_q <= 1'b0;
      osc_run_q <= !s.trim_at_regulator;
      osc_oe_n_q <= s.trim_at_regulator;
      osc_drv_q <= s.trim_at_regulator ? 1'b0 : !osc_drv_q;
    end
  end

  assign bridge_hiz = hiz_q;
  assign bridge_weak_pd = weak_pd_q;
  assign ready = ready_q;
  assign shutdown_flag_n_drv = drv_low_q;
  assign shutdown_flag_n_oe_n = sd_oe_n_q;
  assign temp_warning_n_drv = drv_low_q;
  assign temp_warning_n_oe_n = warn_oe_n_q;
  assign temp_warn_low_n_drv = drv_low_q;
  assign temp_warn_low_n_oe_n = warn_low_oe_n_q;
  assign temp_warn_high_n_drv = drv_low_q;
  assign temp_warn_high_n_oe_n = warn_high_oe_n_q;
  assign osc_run = osc_run_q;
  assign oscillator_io_drv = osc_drv_q;
  assign oscillator_io_oe_n = osc_oe_n_q;

  // ==========================================================
  // Register port
  logic [31:0] status_w;
  always_comb begin
    status_w = '0;
    status_w[pfs_pkg::STAT_STATE_LSB +: 7] = state_q;
    status_w[pfs_pkg::STAT_CHECK_DONE_BIT] = check_done_q;
    status_w[pfs_pkg::STAT_OTE_BIT] = thermal_shutdown_fault_q;
    status_w[pfs_pkg::STAT_OVERLOAD_BIT] = overload_fault_q;
    status_w[pfs_pkg::STAT_UNDERVOLT_BIT] = supply_undervoltage;
    status_w[pfs_pkg::STAT_READY_BIT] = ready_q;
    status_w[pfs_pkg::STAT_PINS_LSB +: 5] = s.pins;
    status_w[pfs_pkg::STAT_BOOT_LSB +: 4] = s.bootstrap_low;
    status_w[pfs_pkg::STAT_OC_LSB +: 4] = s.overcurrent;
  end

  wire sel_ctrl = (reg_addr == pfs_pkg::REG_CTRL);
  wire sel_status = (reg_addr == pfs_pkg::REG_STATUS);
  wire [31:0] rd_mux = sel_ctrl ? ctrl_q : (sel_status ? status_w : 32'h0000_0000);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= pfs_pkg::CTRL_RESET;
      rdata_q <= '0;
    end else begin
      if (reg_wr && sel_ctrl) begin
        ctrl_q <= reg_wdata & pfs_pkg::CTRL_MASK;
      end
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_check_only_once: assert property (check_done_q |-> !in_check)
    else $error("short check ran after it had passed");
  a_short_holds_hiz: assert property (
    (in_check && short_now && !supply_undervoltage) |=> (state_q == $past(state_q)) ##1 (bridge_hiz == 4'hF))
    else $error("short did not hold the bridges off");
  a_check_step_order: assert property (
    $rose(state_q == pfs_pkg::ST_CHECK_SUPPLY) |-> $past(state_q) == pfs_pkg::ST_CHECK_GND)
    else $error("supply step not preceded by ground step");
  a_check_ignores_reset: assert property (
    (state_q == pfs_pkg::ST_CHECK_GND && !s.dev_reset_n && !step_done && !supply_undervoltage)
    |=> state_q == pfs_pkg::ST_CHECK_GND ##1 !shutdown_flag_n_oe_n)
    else $error("check reacted to reset or released flag");
  a_single_ended_skip: assert property (
    (state_q == pfs_pkg::ST_POWER_CLEAR && single_ended) |=> !in_check)
    else $error("check run in single-ended mode");
  a_thermal_latch_hold: assert property (
    (state_q == pfs_pkg::ST_FAULT_LATCH && s.dev_reset_n) |=> state_q == pfs_pkg::ST_FAULT_LATCH)
    else $error("thermal latch left without reset");
  a_undervolt_hiz: assert property (
    (in_run && s.dev_reset_n && supply_undervoltage) |=> state_q == pfs_pkg::ST_UNDERVOLT
    ##1 (bridge_hiz == 4'hF && !shutdown_flag_n_oe_n))
    else $error("undervoltage did not stop the stage");
  a_undervolt_recover: assert property (
    (state_q == pfs_pkg::ST_UNDERVOLT && s.dev_reset_n && !supply_undervoltage) |=> in_run)
    else $error("no automatic recovery after undervoltage");
  a_reset_flag_high: assert property (
    in_held |=> (shutdown_flag_n_oe_n && bridge_hiz == 4'hF))
    else $error("held reset did not release flag or stop bridges");
  a_weak_pulldown: assert property (
    in_held |=> bridge_weak_pd == (($past(single_ended)) ? 4'h0 : 4'hF))
    else $error("weak pulldown wrong for load mode");
  a_ready_overcurrent: assert property ((|s.overcurrent) |=> !ready)
    else $error("ready stayed high on overcurrent");
  a_warn_by_package: assert property (
    (s.temp_over_125) |=> ($past(pkg64) ? !temp_warn_high_n_oe_n && temp_warning_n_oe_n
                                 : !temp_warning_n_oe_n && temp_warn_high_n_oe_n))
    else $error("temperature warning on wrong pin");
  a_osc_slave_mode: assert property (
    s.trim_at_regulator |=> (!osc_run && oscillator_io_oe_n))
    else $error("oscillator not in slave mode");

  c_check_passes: cover property (state_q == pfs_pkg::ST_CHECK_SUPPLY ##1 in_run);
  c_thermal_fault: cover property (in_run ##1 state_q == pfs_pkg::ST_FAULT_LATCH);
  c_undervolt_back: cover property (state_q == pfs_pkg::ST_UNDERVOLT ##1 in_run);
  c_reset_restart: cover property (in_held ##1 in_run);
endmodule

// ---- verilog/pfs_sync.sv ----
/*
  Two-stage synchroniser for every comparator and pin input.
  Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module pfs_sync (
  input wire logic core_clk,
  input wire logic rst,
  pfs_sync_if.sync_side bus
);
  // ==========================================================
  // Stages
  pfs_pkg::pfs_async_t meta_q;
  pfs_pkg::pfs_async_t sync_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= bus.raw;
      sync_q <= meta_q;
    end
  end

  assign bus.synced = sync_q;

  // ==========================================================
  // Checks
  a_sync_two_stage: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst, 2) |-> bus.synced == $past(bus.raw, 2))
    else $error("synchroniser latency is not two cycles");
endmodule
